// file: fault_regs_cfg.svh
// Purpose: Offsets, field positions and reset values of the fault enable and mode register bank
// Assumes: Byte-wide registers addressed by a table number plus an 8-bit offset
// Notes: Definitions only
`ifndef FAULT_REGS_CFG_SVH
`define FAULT_REGS_CFG_SVH

// Table numbers
`define TBL_AREAS 8'h01
`define TBL_ENROW_ALT 8'h05
`define TBL_CONTROL 8'h02

// Offsets in the user and enable tables
`define OFS_AREA_A 8'h80
`define OFS_AREA_B 8'hc0
`define OFS_ALARM_EN_A 8'hf8
`define OFS_ALARM_EN_B 8'hf9
`define OFS_ALARM_EN_FAST 8'hfa
`define OFS_ALARM_EN_RXB 8'hfb
`define OFS_WARN_EN_A 8'hfc
`define OFS_WARN_EN_B 8'hfd
`define OFS_RSVD_EN 8'hfe

// Offsets in the control table
`define OFS_MODE 8'h80
`define OFS_INDEX 8'h81
`define OFS_CONV_MOD 8'h82
`define OFS_CONV_AUXB_LO 8'h87

// Mode register fields
`define MODE_SHADOW_BLOCK 7
`define MODE_AUX_A_AUTO 5
`define MODE_AUX_B_AUTO 4
`define MODE_INDEX_AUTO 3
`define MODE_MOD_AUTO 2
`define MODE_POWER_LOOP_AUTO 1
`define MODE_BIAS_AUTO 0
`define MODE_RESET 8'h3f
`define MODE_WR_MASK 8'hbf

// Enable byte fields that act
`define EN_MON_CD_BITS 8'hf0
`define EN_FAST_BITS 8'h0b
`define EN_RX_LOSS_BITS 8'hc0
`define EN_BIAS_MAX_BIT 3

`endif

// file: fault_regs_pkg.sv
// Purpose: Types and shared decode helpers for the fault enable and mode register bank
// Assumes: fault_regs_cfg.svh supplies all numbers
// Notes: Converter slots are 0 modulation, 1 auxiliary A, 2 auxiliary B
package fault_regs_pkg;
`include "fault_regs_cfg.svh"

	typedef enum logic [2:0] {REG_NONE, REG_AREA_A, REG_AREA_B, REG_EN_ROW, REG_MODE, REG_INDEX, REG_CONV} region_t;

	// Converter slot from a control-table offset, two bytes per converter
	function automatic logic [1:0] conv_slot(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - `OFS_CONV_MOD;
		return rel[2:1];
	endfunction

	// Auto bit of a converter slot
	function automatic logic conv_auto(input logic [7:0] mode, input logic [1:0] slot);
		logic a;
		a = mode[`MODE_MOD_AUTO];
		if (slot == 2'h1) a = mode[`MODE_AUX_A_AUTO];
		if (slot == 2'h2) a = mode[`MODE_AUX_B_AUTO];
		return a;
	endfunction

	// Byte index into the user and enable storage
	function automatic logic [6:0] mem_idx(input logic [7:0] addr);
		return addr[6:0];
	endfunction
endpackage

// file: access_if.sv
// Purpose: Carries an access request and its permission verdict between bank and gate
// Assumes: Single clock, purely combinational verdict
// Notes: None
`timescale 1ns/1ps
interface access_if;
	import fault_regs_pkg::*;
	logic [7:0] table_sel;
	logic [7:0] addr;
	logic [7:0] mode;
	logic row_in_alt;
	logic upper;
	logic lower;
	logic rw_a;
	logic ro_a;
	logic rw_b;
	logic ro_b;
	logic rw_c;
	logic ro_c;
	logic rw_2;
	logic ro_2;
	logic wp_2;
	region_t region;
	logic rd_ok;
	logic wr_ok;

	modport gate (input table_sel, addr, mode, row_in_alt, upper, lower, rw_a, ro_a, rw_b, ro_b,
		rw_c, ro_c, rw_2, ro_2, wp_2, output region, rd_ok, wr_ok);
	modport user (output table_sel, addr, mode, row_in_alt, upper, lower, rw_a, ro_a, rw_b, ro_b,
		rw_c, ro_c, rw_2, ro_2, wp_2, input region, rd_ok, wr_ok);
endinterface

// file: access_gate.sv
// Purpose: Decodes table and offset into a region and grants read or write by password level
// Assumes: Inputs stable for the cycle of the access
// Notes: Unmapped locations decode to REG_NONE and are never granted
`timescale 1ns/1ps
`include "fault_regs_cfg.svh"
module access_gate
	import fault_regs_pkg::*;
(
	// Request and verdict
	access_if.gate acc
);

	// Upper level always passes, lower level needs the matching permission
	function automatic logic lvl_ok(input logic up, input logic lo, input logic perm);
		return up | (lo & perm);
	endfunction

	// Region decode and grant
	always_comb begin
		acc.region = REG_NONE;
		acc.rd_ok = 1'b0;
		acc.wr_ok = 1'b0;
		if (acc.table_sel == `TBL_AREAS && acc.addr >= `OFS_AREA_A && acc.addr < `OFS_AREA_B) begin
			acc.region = REG_AREA_A;
			acc.rd_ok = lvl_ok(acc.upper, acc.lower, acc.rw_a | acc.ro_a);
			acc.wr_ok = lvl_ok(acc.upper, acc.lower, acc.rw_a);
		end else if (acc.table_sel == `TBL_AREAS && acc.addr >= `OFS_AREA_B && acc.addr < `OFS_ALARM_EN_A) begin
			acc.region = REG_AREA_B;
			acc.rd_ok = lvl_ok(acc.upper, acc.lower, acc.rw_b | acc.ro_b);
			acc.wr_ok = lvl_ok(acc.upper, acc.lower, acc.rw_b);
		end else if (acc.addr >= `OFS_ALARM_EN_A &&
			acc.table_sel == (acc.row_in_alt ? `TBL_ENROW_ALT : `TBL_AREAS)) begin
			acc.region = REG_EN_ROW;
			acc.rd_ok = lvl_ok(acc.upper, acc.lower, acc.rw_c | acc.ro_c);
			acc.wr_ok = lvl_ok(acc.upper, acc.lower, acc.rw_c);
		end else if (acc.table_sel == `TBL_CONTROL) begin
			if (acc.addr == `OFS_MODE) begin
				acc.region = REG_MODE;
				acc.rd_ok = lvl_ok(acc.upper, acc.lower, acc.rw_2 | acc.ro_2);
				acc.wr_ok = lvl_ok(acc.upper, acc.lower, acc.wp_2);
			end else if (acc.addr == `OFS_INDEX) begin
				acc.region = REG_INDEX;
				acc.rd_ok = lvl_ok(acc.upper, acc.lower, acc.rw_2 | acc.ro_2);
				acc.wr_ok = lvl_ok(acc.upper, acc.lower, acc.rw_2) & ~acc.mode[`MODE_INDEX_AUTO];
			end else if (acc.addr >= `OFS_CONV_MOD && acc.addr <= `OFS_CONV_AUXB_LO) begin
				acc.region = REG_CONV;
				acc.rd_ok = lvl_ok(acc.upper, acc.lower, acc.rw_2 | acc.ro_2);
				// Host value is writable only while table recall is off
				acc.wr_ok = lvl_ok(acc.upper, acc.lower, acc.rw_2) & ~conv_auto(acc.mode, conv_slot(acc.addr));
			end
		end
	end
endmodule

// file: fault_regs.sv
// Purpose: Password-guarded user areas, alarm and warning enable masks and the volatile mode register
// Assumes: Host byte port comes from the serial slave on the same clock; status bytes are same-clock logic
// Notes: Storage is the volatile copy; nonvolatile commits leave as one-cycle requests
//
// Summary of operation
// - Area A read/write gated by area-A permissions
// - Enable row read/write gated by area-C permissions
// - First alarm mask gates eight monitor alarms
// - Second alarm mask gates monitors C, D
// - Fast-trip mask bits drive laser shutdown gate
// - Bias-maximum mask bit drives laser shutdown gate
// - Receive-loss mask bits gate the interrupt flag
// - First warning mask gates eight warnings
// - Second warning mask gates monitors C, D
// - Select bit maps row table one/five
// - Mode register readable by level, powers up 3Fh
// - Shadow block stops nonvolatile commit of row
// - Aux A manual value applies at STOP
// - Aux B manual value applies at STOP
// - Modulation manual value applies at STOP
// - Auto bits set: converters follow lookup values
// - Index manual when index auto bit clear
// - Interrupt ORs enabled events plus unmaskable alarms
`timescale 1ns/1ps
// Offsets and field positions; the guard keeps a second inclusion harmless
`include "fault_regs_cfg.svh"
module fault_regs
	import fault_regs_pkg::*;
#(
	parameter int CONV_W = 9
) (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Host byte port
	input wire logic [7:0] host_table,
	input wire logic [7:0] host_addr,
	input wire logic host_wr,
	input wire logic [7:0] host_wdata,
	input wire logic host_rd,
	input wire logic host_stop,
	output logic [7:0] read_data,
	output logic read_ack,
	// Password level and permissions
	input wire logic upper_password_level,
	input wire logic lower_password_level,
	input wire logic area_a_readwrite_perm,
	input wire logic area_a_readonly_perm,
	input wire logic area_b_readwrite_perm,
	input wire logic area_b_readonly_perm,
	input wire logic area_c_readwrite_perm,
	input wire logic area_c_readonly_perm,
	input wire logic table_two_readwrite_perm,
	input wire logic table_two_readonly_perm,
	input wire logic table_two_write_perm,
	input wire logic enable_row_in_alt_table,
	// Alarm and warning status
	input wire logic [7:0] alarm_monitors_a,
	input wire logic [7:0] alarm_monitors_b,
	input wire logic [7:0] alarm_fast_trip,
	input wire logic [7:0] alarm_rx_and_bias,
	input wire logic [7:0] warning_monitors_a,
	input wire logic [7:0] warning_monitors_b,
	// Temperature lookup side
	input wire logic conversion_done,
	input wire logic [7:0] calc_index,
	input wire logic [CONV_W-1:0] mod_lut_value,
	input wire logic [CONV_W-1:0] aux_a_lut_value,
	input wire logic [CONV_W-1:0] aux_b_lut_value,
	// Nonvolatile commit request
	output logic nv_write,
	output logic [7:0] nv_addr,
	output logic [7:0] nv_data,
	// Control outputs
	output logic fault_interrupt_flag,
	output logic laser_shutdown_gate,
	output logic [CONV_W-1:0] mod_value,
	output logic [CONV_W-1:0] aux_a_value,
	output logic [CONV_W-1:0] aux_b_value,
	output logic [7:0] temperature_table_index,
	output logic power_loop_auto,
	output logic bias_auto,
	output logic shadow_write_block
);

	// Byte split below assumes a high byte exists and fits
	if (CONV_W < 9 || CONV_W > 16) begin : g_bad_width
		$error("fault_regs: CONV_W must be 9 to 16");
	end

	typedef struct packed {
		logic [127:0][7:0] mem;
		logic [7:0] mode;
		logic [7:0] index;
		logic [2:0][CONV_W-1:0] live;
		logic [2:0][CONV_W-1:0] stage;
		logic [7:0] rd_data;
		logic rd_ack;
		logic nv_write;
		logic [7:0] nv_addr;
		logic [7:0] nv_data;
		logic fault;
		logic shutdown;
	} state_t;

	localparam state_t STATE_RESET = '{mode: `MODE_RESET, default: '0};

	state_t q;
	state_t d;
	logic [7:0] rd_byte;
	logic [1:0] slot;
	logic [2:0][CONV_W-1:0] lut_vals;
	access_if acc();

	access_gate u_gate (
		.acc(acc.gate)
	);

	// Request to the permission gate
	assign acc.table_sel = host_table;
	assign acc.addr = host_addr;
	assign acc.mode = q.mode;
	assign acc.row_in_alt = enable_row_in_alt_table;
	assign acc.upper = upper_password_level;
	assign acc.lower = lower_password_level;
	assign acc.rw_a = area_a_readwrite_perm;
	assign acc.ro_a = area_a_readonly_perm;
	assign acc.rw_b = area_b_readwrite_perm;
	assign acc.ro_b = area_b_readonly_perm;
	assign acc.rw_c = area_c_readwrite_perm;
	assign acc.ro_c = area_c_readonly_perm;
	assign acc.rw_2 = table_two_readwrite_perm;
	assign acc.ro_2 = table_two_readonly_perm;
	assign acc.wp_2 = table_two_write_perm;

	assign slot = conv_slot(host_addr);
	assign lut_vals = {aux_b_lut_value, aux_a_lut_value, mod_lut_value};

	// Read data mux; reserved enable bytes read back as stored
	always_comb begin
		rd_byte = 8'h00;
		unique case (acc.region)
			REG_AREA_A, REG_AREA_B, REG_EN_ROW: rd_byte = q.mem[mem_idx(host_addr)];
			REG_MODE: rd_byte = q.mode;
			REG_INDEX: rd_byte = q.index;
			REG_CONV: rd_byte = host_addr[0] ? q.live[slot][7:0] : 8'(q.live[slot] >> 8);
			REG_NONE: rd_byte = 8'h00;
		endcase
	end

	// Next state
	always_comb begin
		d = q;
		d.rd_ack = 1'b0;
		d.nv_write = 1'b0;
		// A refused read answers with zero rather than stalling the host
		if (host_rd) begin
			d.rd_ack = 1'b1;
			d.rd_data = acc.rd_ok ? rd_byte : 8'h00;
		end
		if (host_wr && acc.wr_ok) begin
			unique case (acc.region)
				REG_AREA_A, REG_AREA_B: begin
					d.mem[mem_idx(host_addr)] = host_wdata;
					d.nv_write = 1'b1;
				end
				REG_EN_ROW: begin
					d.mem[mem_idx(host_addr)] = host_wdata;
					d.nv_write = ~q.mode[`MODE_SHADOW_BLOCK];
				end
				REG_MODE: d.mode = host_wdata & `MODE_WR_MASK;
				REG_INDEX: d.index = host_wdata;
				REG_CONV: begin
					if (host_addr[0]) begin
						d.stage[slot][7:0] = host_wdata;
					end else begin
						d.stage[slot][CONV_W-1:8] = host_wdata[CONV_W-9:0];
					end
				end
				REG_NONE: d.nv_write = 1'b0;
			endcase
			d.nv_addr = host_addr;
			d.nv_data = host_wdata;
		end
		// Index follows the thermometer only in auto mode
		if (q.mode[`MODE_INDEX_AUTO] && conversion_done) begin
			d.index = calc_index;
		end
		// Converters: table recall in auto mode, staged host value at STOP otherwise
		for (int k = 0; k < 3; k++) begin
			if (conv_auto(q.mode, 2'(k))) begin
				if (conversion_done) begin
					d.live[k] = lut_vals[k];
				end
			end else if (host_stop) begin
				d.live[k] = d.stage[k];
			end
		end
		// Interrupt: masked monitor events plus fast-trip and bias-maximum alarms that no mask can hide
		d.fault = (|(alarm_monitors_a & q.mem[mem_idx(`OFS_ALARM_EN_A)]))
			| (|(alarm_monitors_b & q.mem[mem_idx(`OFS_ALARM_EN_B)] & `EN_MON_CD_BITS))
			| (|(warning_monitors_a & q.mem[mem_idx(`OFS_WARN_EN_A)]))
			| (|(warning_monitors_b & q.mem[mem_idx(`OFS_WARN_EN_B)] & `EN_MON_CD_BITS))
			| (|(alarm_rx_and_bias & q.mem[mem_idx(`OFS_ALARM_EN_RXB)] & `EN_RX_LOSS_BITS))
			| (|(alarm_fast_trip & `EN_FAST_BITS)) | alarm_rx_and_bias[`EN_BIAS_MAX_BIT];
		// Shutdown gate sees only the fast-trip and bias-maximum masks
		d.shutdown = (|(alarm_fast_trip & q.mem[mem_idx(`OFS_ALARM_EN_FAST)] & `EN_FAST_BITS))
			| (alarm_rx_and_bias[`EN_BIAS_MAX_BIT]
			& q.mem[mem_idx(`OFS_ALARM_EN_RXB)][`EN_BIAS_MAX_BIT]);
	end

	// State register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			q <= STATE_RESET;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign read_data = q.rd_data;
	assign read_ack = q.rd_ack;
	assign nv_write = q.nv_write;
	assign nv_addr = q.nv_addr;
	assign nv_data = q.nv_data;
	assign fault_interrupt_flag = q.fault;
	assign laser_shutdown_gate = q.shutdown;
	assign mod_value = q.live[0];
	assign aux_a_value = q.live[1];
	assign aux_b_value = q.live[2];
	assign temperature_table_index = q.index;
	assign power_loop_auto = q.mode[`MODE_POWER_LOOP_AUTO];
	assign bias_auto = q.mode[`MODE_BIAS_AUTO];
	assign shadow_write_block = q.mode[`MODE_SHADOW_BLOCK];

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	chk_area_a_denied: assert property (
		host_rd && host_table == `TBL_AREAS && host_addr >= `OFS_AREA_A && host_addr < `OFS_AREA_B
		&& !upper_password_level && !area_a_readwrite_perm && !area_a_readonly_perm
		|=> read_ack && read_data == 8'h00)
		else $error("area A read leaked without permission");

	chk_area_b_loop: assert property (
		host_wr && acc.wr_ok && acc.region == REG_AREA_B ##1 !host_wr
		##1 host_rd && acc.rd_ok && host_addr == $past(host_addr, 2) && host_table == $past(host_table, 2)
		|=> read_data == $past(host_wdata, 3))
		else $error("area B write not read back");

	chk_row_unmapped: assert property (
		host_rd && host_table == `TBL_ENROW_ALT && host_addr >= `OFS_ALARM_EN_A && !enable_row_in_alt_table
		|=> read_data == 8'h00)
		else $error("unused enable row location not empty");

	chk_fault_mask: assert property (
		(|(alarm_monitors_a & q.mem[mem_idx(`OFS_ALARM_EN_A)])) |=> fault_interrupt_flag)
		else $error("enabled alarm did not raise the interrupt flag");

	chk_fault_unmasked: assert property (
		alarm_fast_trip[1] || alarm_rx_and_bias[3] |=> fault_interrupt_flag)
		else $error("unmaskable alarm did not raise the interrupt flag");

	chk_fault_quiet: assert property (
		alarm_monitors_a == 8'h00 && alarm_monitors_b[7:4] == 4'h0 && alarm_fast_trip == 8'h00
		&& alarm_rx_and_bias == 8'h00 && warning_monitors_a == 8'h00 && warning_monitors_b[7:4] == 4'h0
		|=> !fault_interrupt_flag)
		else $error("interrupt flag raised with no event");

	chk_shutdown_gate: assert property (
		alarm_fast_trip[3] && q.mem[mem_idx(`OFS_ALARM_EN_FAST)][3] |=> laser_shutdown_gate)
		else $error("enabled high-bias alarm did not gate the laser");

	chk_bias_shutdown: assert property (
		alarm_rx_and_bias[3] && q.mem[mem_idx(`OFS_ALARM_EN_RXB)][3] |=> laser_shutdown_gate)
		else $error("enabled bias-maximum alarm did not gate the laser");

	chk_mode_update: assert property (
		host_wr && acc.wr_ok && acc.region == REG_MODE
		|=> {power_loop_auto, bias_auto, shadow_write_block} == {$past(host_wdata[1:0]), $past(host_wdata[7])})
		else $error("mode bits did not take the granted write");

	chk_shadow_block: assert property (
		host_wr && acc.wr_ok && acc.region == REG_EN_ROW |=> nv_write == !$past(q.mode[`MODE_SHADOW_BLOCK]))
		else $error("nonvolatile commit disagrees with shadow block bit");

	chk_manual_stop: assert property (
		!q.mode[`MODE_AUX_B_AUTO] && host_stop && !host_wr |=> aux_b_value == $past(q.stage[2]))
		else $error("manual auxiliary B value not applied at STOP");

	chk_auto_recall: assert property (
		q.mode[`MODE_MOD_AUTO] && conversion_done |=> mod_value == $past(mod_lut_value))
		else $error("modulation value did not follow lookup");

	chk_index_hold: assert property (
		!q.mode[`MODE_INDEX_AUTO] && !host_wr |=> $stable(temperature_table_index))
		else $error("manual index changed without a host write");

	cov_manual_write: cover property (host_wr && acc.region == REG_CONV && acc.wr_ok ##[1:8] host_stop);
	cov_row_alt: cover property (host_wr && acc.wr_ok && host_table == `TBL_ENROW_ALT);
	cov_shutdown: cover property (!laser_shutdown_gate ##1 laser_shutdown_gate);
endmodule

// file: host_model.sv
// Purpose: Serial host stand-in that issues byte writes, byte reads and the STOP condition
// Assumes: Every request is launched 1 ns after a rising edge and held across one sampling edge
// Notes: Write data is inverted once released, so a stale byte can never pass for a fresh one
`timescale 1ns/1ps
module host_model (
	// Clock
	input wire logic clock,
	// Byte port toward the bank
	output logic [7:0] host_table,
	output logic [7:0] host_addr,
	output logic host_wr,
	output logic [7:0] host_wdata,
	output logic host_rd,
	output logic host_stop,
	input wire logic [7:0] read_data,
	input wire logic read_ack
);
	// Idle bus from time zero
	initial begin
		host_table = 8'h00;
		host_addr = 8'h00;
		host_wr = 1'b0;
		host_wdata = 8'h00;
		host_rd = 1'b0;
		host_stop = 1'b0;
	end

	// One byte write; the strobe stands for exactly one sampling edge
	task automatic wr(input logic [7:0] t, input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		#1;
		host_table = t;
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		@(posedge clock);
		#1;
		host_wr = 1'b0;
		host_wdata = ~d;
	endtask

	// One byte read; answer is taken 1 ns after the edge that sampled the strobe
	task automatic rd(input logic [7:0] t, input logic [7:0] a, output logic [7:0] d, output logic k);
		@(posedge clock);
		#1;
		host_table = t;
		host_addr = a;
		host_rd = 1'b1;
		@(posedge clock);
		#1;
		host_rd = 1'b0;
		d = read_data;
		k = read_ack;
	endtask

	// End of the write cycle, which is when manual converter values apply
	task automatic stop();
		@(posedge clock);
		#1;
		host_stop = 1'b1;
		@(posedge clock);
		#1;
		host_stop = 1'b0;
	endtask
endmodule

// file: fault_enable_and_mode_regs_test.sv
// Purpose: Self-checking bench for the fault enable and mode register bank
// Assumes: Host stand-in launches requests 1 ns after each rising edge
// Notes: Access rights in table rows first, then masks, converters and a second reset by hand
`timescale 1ns/1ps
module fault_enable_and_mode_regs_test;
	typedef struct packed {logic [7:0] t; logic [7:0] a; logic [1:0] lv; logic [8:0] pm; logic [7:0] d;
		logic [7:0] e;} row_t;
	logic clock;
	logic nrst;
	logic [1:0] lv;
	logic [8:0] pm;
	logic enable_row_in_alt_table;
	logic [7:0] alarm_monitors_a, alarm_monitors_b, alarm_fast_trip, alarm_rx_and_bias;
	logic [7:0] warning_monitors_a, warning_monitors_b, calc_index, temperature_table_index;
	logic [7:0] host_table, host_addr, host_wdata, read_data, nv_addr, nv_data;
	logic host_wr, host_rd, host_stop, read_ack, nv_write, conversion_done;
	logic fault_interrupt_flag, laser_shutdown_gate, power_loop_auto, bias_auto, shadow_write_block;
	logic [8:0] mod_lut_value, aux_a_lut_value, aux_b_lut_value, mod_value, aux_a_value, aux_b_value;
	row_t rows [12];
	int n_errors = 0;
	int check_count = 0;
	int nv_cnt = 0;
	int cyc = 0;

	// Serial host stand-in
	host_model host_u (.clock, .host_table, .host_addr, .host_wr, .host_wdata, .host_rd, .host_stop,
		.read_data, .read_ack);

	// Bank under test; level bits are {upper, lower}, rights are {a rw, a ro, b rw, b ro, c rw, c ro, t2 rw, ro, wr}
	fault_regs #(.CONV_W(9)) dut_u (.clock, .nrst, .host_table, .host_addr, .host_wr, .host_wdata, .host_rd,
		.host_stop, .read_data, .read_ack, .upper_password_level(lv[1]), .lower_password_level(lv[0]),
		.area_a_readwrite_perm(pm[8]), .area_a_readonly_perm(pm[7]), .area_b_readwrite_perm(pm[6]),
		.area_b_readonly_perm(pm[5]), .area_c_readwrite_perm(pm[4]), .area_c_readonly_perm(pm[3]),
		.table_two_readwrite_perm(pm[2]), .table_two_readonly_perm(pm[1]), .table_two_write_perm(pm[0]),
		.enable_row_in_alt_table, .alarm_monitors_a, .alarm_monitors_b, .alarm_fast_trip, .alarm_rx_and_bias,
		.warning_monitors_a, .warning_monitors_b, .conversion_done, .calc_index, .mod_lut_value,
		.aux_a_lut_value, .aux_b_lut_value, .nv_write, .nv_addr, .nv_data, .fault_interrupt_flag,
		.laser_shutdown_gate, .mod_value, .aux_a_value, .aux_b_value, .temperature_table_index,
		.power_loop_auto, .bias_auto, .shadow_write_block);

	// 200 MHz clock
	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// Count commit pulses; the ceiling is about twenty times the expected run of some 144 cycles
	always @(posedge clock) begin
		cyc++;
		if (nv_write === 1'b1) nv_cnt++;
		if (cyc == 3000) begin
			n_errors++;
			end_sim();
		end
	end

	// Compare and report at once
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Read one byte and compare it, acknowledge included
	task automatic rchk(input logic [7:0] t, input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic k;
		host_u.rd(t, a, d, k);
		check(16'(k), 16'h1);
		check(16'(d), 16'(e));
	endtask

	// Status bytes in, then {interrupt, shutdown} exactly one cycle later
	task automatic st(input logic [47:0] v, input logic [1:0] e);
		@(posedge clock);
		#1;
		{alarm_monitors_a, alarm_monitors_b, alarm_fast_trip, alarm_rx_and_bias, warning_monitors_a,
			warning_monitors_b} = v;
		@(posedge clock);
		#1;
		check(16'({fault_interrupt_flag, laser_shutdown_gate}), 16'(e));
	endtask

	// One temperature conversion completing with the given lookup results
	task automatic conv(input logic [7:0] ci, input logic [8:0] m, input logic [8:0] a, input logic [8:0] b);
		@(posedge clock);
		#1;
		calc_index = ci;
		{mod_lut_value, aux_a_lut_value, aux_b_lut_value} = {m, a, b};
		conversion_done = 1'b1;
		@(posedge clock);
		#1;
		conversion_done = 1'b0;
	endtask

	// Verdict and end of run
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		nrst = 1'b0;
		lv = 2'b00;
		pm = 9'h000;
		enable_row_in_alt_table = 1'b0;
		{alarm_monitors_a, alarm_monitors_b, alarm_fast_trip, alarm_rx_and_bias} = 32'h0;
		{warning_monitors_a, warning_monitors_b, calc_index} = 24'h0;
		{mod_lut_value, aux_a_lut_value, aux_b_lut_value} = 27'h0;
		conversion_done = 1'b0;
		rows = '{
			'{8'h01, 8'h80, 2'b10, 9'h000, 8'h5a, 8'h5a},
			'{8'h01, 8'h81, 2'b01, 9'h100, 8'ha5, 8'ha5},
			'{8'h01, 8'h81, 2'b01, 9'h080, 8'h3c, 8'ha5},
			'{8'h01, 8'h80, 2'b01, 9'h000, 8'h11, 8'h00},
			'{8'h01, 8'hc0, 2'b01, 9'h040, 8'h66, 8'h66},
			'{8'h01, 8'hc0, 2'b01, 9'h100, 8'h77, 8'h00},
			'{8'h01, 8'hf9, 2'b01, 9'h010, 8'hf0, 8'hf0},
			'{8'h01, 8'hfc, 2'b10, 9'h000, 8'h81, 8'h81},
			'{8'h01, 8'hfe, 2'b01, 9'h010, 8'h9c, 8'h9c},
			'{8'h01, 8'hfc, 2'b01, 9'h008, 8'h30, 8'h81},
			'{8'h05, 8'hf8, 2'b10, 9'h000, 8'h12, 8'h00},
			'{8'h02, 8'h80, 2'b01, 9'h002, 8'h00, 8'h3f}};
		repeat (5) @(posedge clock);
		#1;
		nrst = 1'b1;
		check(16'({power_loop_auto, bias_auto, shadow_write_block}), 16'h6);
		// Each row writes, then reads back under the same rights
		foreach (rows[i]) begin
			lv = rows[i].lv;
			pm = rows[i].pm;
			host_u.wr(rows[i].t, rows[i].a, rows[i].d);
			rchk(rows[i].t, rows[i].a, rows[i].e);
		end
		check(16'(nv_cnt), 16'd6);
		check({nv_addr, nv_data}, 16'hfe9c);
		// Masks: F8 bit 0, F9 high nibble, FC bits 7 and 0, FD bit 6
		lv = 2'b10;
		pm = 9'h000;
		host_u.wr(8'h01, 8'hf8, 8'h01);
		host_u.wr(8'h01, 8'hfd, 8'h40);
		st(48'h0200_0000_0000, 2'b00);
		st(48'h0100_0000_0000, 2'b10);
		st(48'h0008_0000_0000, 2'b00);
		st(48'h0010_0000_0000, 2'b10);
		st(48'h0000_0000_8000, 2'b10);
		st(48'h0000_0000_4000, 2'b00);
		st(48'h0000_0000_0040, 2'b10);
		st(48'h0000_0000_0080, 2'b00);
		st(48'h0000_0800_0000, 2'b10);
		st(48'h0000_0400_0000, 2'b00);
		st(48'h0000_0008_0000, 2'b10);
		st(48'h0000_0080_0000, 2'b00);
		host_u.wr(8'h01, 8'hfa, 8'h0b);
		host_u.wr(8'h01, 8'hfb, 8'hc8);
		st(48'h0000_0100_0000, 2'b11);
		st(48'h0000_0200_0000, 2'b11);
		st(48'h0000_0800_0000, 2'b11);
		st(48'h0000_0008_0000, 2'b11);
		st(48'h0000_0040_0000, 2'b10);
		st(48'h0000_0000_0000, 2'b00);
		// Moving the row leaves the old place empty
		enable_row_in_alt_table = 1'b1;
		rchk(8'h01, 8'hf9, 8'h00);
		rchk(8'h05, 8'hf9, 8'hf0);
		enable_row_in_alt_table = 1'b0;
		// Shadow block on, modulation manual: row write stays volatile, value waits for STOP
		host_u.wr(8'h02, 8'h80, 8'hbb);
		host_u.wr(8'h01, 8'hf8, 8'h03);
		host_u.wr(8'h02, 8'h82, 8'h01);
		host_u.wr(8'h02, 8'h83, 8'h23);
		rchk(8'h01, 8'hf8, 8'h03);
		check(16'(nv_cnt), 16'd10);
		check(16'({shadow_write_block, mod_value}), 16'h200);
		host_u.stop();
		check(16'(mod_value), 16'h123);
		conv(8'h9c, 9'h1ff, 9'h0aa, 9'h155);
		check(16'(mod_value), 16'h123);
		check(16'(aux_a_value), 16'h0aa);
		check(16'(aux_b_value), 16'h155);
		check(16'(temperature_table_index), 16'h9c);
		// Everything manual
		host_u.wr(8'h02, 8'h80, 8'h80);
		check(16'({power_loop_auto, bias_auto}), 16'h0);
		host_u.wr(8'h02, 8'h84, 8'h00);
		host_u.wr(8'h02, 8'h85, 8'h44);
		host_u.wr(8'h02, 8'h86, 8'h01);
		host_u.wr(8'h02, 8'h87, 8'h02);
		host_u.wr(8'h02, 8'h81, 8'h55);
		host_u.stop();
		conv(8'h11, 9'h000, 9'h000, 9'h000);
		check(16'(aux_a_value), 16'h044);
		check(16'(aux_b_value), 16'h102);
		check(16'(temperature_table_index), 16'h55);
		// Shadow block cleared, then the row byte rewritten so it is committed to nonvolatile memory
		host_u.wr(8'h02, 8'h80, 8'h00);
		host_u.wr(8'h01, 8'hf8, 8'h03);
		check(16'({nv_write, nv_data}), 16'h103);
		// Second reset in mid-run
		nrst = 1'b0;
		#1;
		check(16'({mod_value, power_loop_auto, bias_auto}), 16'h3);
		repeat (5) @(posedge clock);
		#1;
		nrst = 1'b1;
		lv = 2'b01;
		pm = 9'h002;
		rchk(8'h02, 8'h80, 8'h3f);
		// Back in auto mode: modulation and index follow the conversion
		conv(8'h21, 9'h1a5, 9'h0f0, 9'h00f);
		check(16'(mod_value), 16'h1a5);
		check(16'(temperature_table_index), 16'h21);
		end_sim();
	end
endmodule
